// *** rtl/rfes_top.sv ***
// Reader data buffer, its control registers and the first event status register
// Operation
// R1: Threshold register at 03h, ninth bit in buffer control for 512-byte depth.
// R2: Near-empty flag is 1 when stored bytes are at or below threshold.
// R3: Near-full flag is 1 when depth minus stored bytes is at or below threshold.
// R4: Depth select 1 gives 255 bytes, 0 gives 512; change only when empty. The code takes the write at any fill level.
// R5: Writing 1 to buffer clear empties buffer and count; reads back 0.
// R6: Count bits 9 and 8 appear in buffer control, bits 7..0 at 04h.
// R7: Byte count at 04h resets to zero and is changed by hardware only.
// R8: Data port write pushes and increments count; read pops and decrements.
// R9: Data port accesses leave the address pointer; other accesses advance it.
// R10: Event status at 06h resets to zero; bits 6..0 latched, bit 7 write-only.
// R11: Write with bit 7 set sets ones in 6..0, with bit 7 clear clears them.
// R12: Near-full event latches on rising flag and holds until cleared.
// R13: Near-empty event latches on rising flag and holds until cleared.
// R14: Command-done event sets when a running command ends and field returns idle.
// R15: Starting an undefined command returns field to idle and sets command-done.
// R16: Host starting the idle command does not set command-done.
// R17: Transmit-done event sets once the last outgoing bit is sent.
// R18: Receive-end event sets at end of incoming stream, errors or not.
// R19: Host checks error flags after receive-end before trusting data.
// R20: Error event sets when any of five error flags becomes set.
// R21: Frame-start event sets on start-of-frame or subcarrier detection.
// R22: Hardware set beats a same-cycle software clear; bit 7 reads 0.
`timescale 1ns/1ps

module rfes_top
  import rfes_pkg::*;
#(
  parameter logic [31:0] CMD_DEFINED_MASK = 32'h0000_FFFF
)(
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire rfes_acc_t    acc_i,
  input  wire rfes_hw_evt_t hw_evt_i,
  input  wire logic         cmd_start_i,
  input  wire logic [4:0]   cmd_code_i,
  input  wire logic         cmd_self_end_i,
  output logic [7:0]        rdata_o,
  output logic              rvalid_o,
  output logic [6:0]        addr_ptr_o,
  output logic [4:0]        cmd_field_o,
  output logic [6:0]        events_o,
  output logic              near_full_o,
  output logic              near_empty_o,
  output logic [9:0]        byte_count_o
);

  // ==========================================================================
  // Elaboration checks
  // The idle code must count as defined, or idle could never be started cleanly
  if (CMD_DEFINED_MASK[RFES_CMD_IDLE] != 1'b1)
  begin : g_bad_mask
    $error("CMD_DEFINED_MASK must mark the idle command as defined");
  end

  // Storage is sized for the deep setting; a larger depth would overrun it
  if (RFES_DEPTH_LARGE > 10'h200)
  begin : g_bad_depth
    $error("Deep setting exceeds the buffer storage");
  end

  // ==========================================================================
  // Storage and state
  logic [7:0] mem [0:511];
  logic [8:0] wr_ptr;
  logic [8:0] rd_ptr;
  logic [9:0] count;
  logic       depth_sel;
  logic [8:0] threshold;
  logic [6:0] events;
  logic [6:0] addr_ptr;
  logic [4:0] cmd_field;
  logic       near_full_q;
  logic       near_empty_q;
  logic [4:0] err_q;

  // ==========================================================================
  // Access decode
  logic       wr_any;
  logic       rd_any;
  logic       hit_ctl;
  logic       hit_thr;
  logic       hit_port;
  logic       hit_evt;
  logic       push;
  logic       pop;
  logic       flush;
  logic [9:0] depth;
  logic [9:0] thr_eff;
  logic [9:0] gap;
  logic       near_full;
  logic       near_empty;
  logic [6:0] hw_set;
  logic       cmd_done_set;
  logic       cmd_defined;

  // Decode uses the live pointer; a load in the same cycle steers only the next access
  assign wr_any   = acc_i.valid & acc_i.write;
  assign rd_any   = acc_i.valid & ~acc_i.write;
  assign hit_ctl  = (addr_ptr == RFES_OFS_BUFFER_CONTROL);
  assign hit_thr  = (addr_ptr == RFES_OFS_FILL_THRESHOLD);
  assign hit_port = (addr_ptr == RFES_OFS_ACCESS_PORT);
  assign hit_evt  = (addr_ptr == RFES_OFS_EVENT_STATUS);

  // Clear request; wins over a push or pop in the same cycle
  assign flush = wr_any & hit_ctl & acc_i.wdata[RFES_CTL_CLEAR_BIT]; // R5

  // Overfull writes and empty reads are dropped so the count never wraps
  assign depth = depth_sel ? RFES_DEPTH_SMALL : RFES_DEPTH_LARGE; // R4
  assign push  = wr_any & hit_port & (count < depth) & ~flush;    // R8
  assign pop   = rd_any & hit_port & (count != 10'h000);          // R8

  // ==========================================================================
  // Alert flags
  // Ninth threshold bit only counts in the deep setting
  assign thr_eff = depth_sel ? {2'b00, threshold[7:0]} : {1'b0, threshold}; // R1
  // Guard against a depth change while holding more than the small depth
  assign gap        = (count >= depth) ? 10'h000 : (depth - count);
  assign near_full  = (gap <= thr_eff);   // R3
  assign near_empty = (count <= thr_eff); // R2

  // ==========================================================================
  // Command field: idle, running, or bounced back from an undefined code
  assign cmd_defined = CMD_DEFINED_MASK[cmd_code_i];

  // A start beats a self end in one cycle, so a new command is never dropped
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cmd_field <= RFES_CMD_IDLE;
    end
    else if (cmd_start_i)
    begin
      // Undefined codes never reach the field; it is set to idle
      cmd_field <= cmd_defined ? cmd_code_i : RFES_CMD_IDLE; // R15
    end
    else if (cmd_self_end_i && (cmd_field != RFES_CMD_IDLE))
    begin
      cmd_field <= RFES_CMD_IDLE; // R14
    end
  end

  // Host idle start sets nothing; only self ends and bounced codes do
  assign cmd_done_set = (cmd_start_i & ~cmd_defined) // R15
                      | (~cmd_start_i & cmd_self_end_i
                         & (cmd_field != RFES_CMD_IDLE)); // R14 R16

  // ==========================================================================
  // Hardware event sources, rising edges of flags and plain pulses
  always_comb
  begin
    hw_set = 7'h00;
    hw_set[RFES_EVT_NEAR_FULL]   = near_full & ~near_full_q;    // R12
    hw_set[RFES_EVT_NEAR_EMPTY]  = near_empty & ~near_empty_q;  // R13
    hw_set[RFES_EVT_CMD_DONE]    = cmd_done_set;
    hw_set[RFES_EVT_TX_DONE]     = hw_evt_i.tx_done;            // R17
    hw_set[RFES_EVT_RX_END]      = hw_evt_i.rx_end;             // R18
    hw_set[RFES_EVT_ERROR]       = |(hw_evt_i.error_flags & ~err_q); // R20
    hw_set[RFES_EVT_FRAME_START] = hw_evt_i.frame_start;        // R21
  end

  // Previous flag levels; reset matches an empty buffer so no spurious edge
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      near_full_q  <= 1'b0;
      near_empty_q <= 1'b1;
      err_q        <= 5'h00;
    end
    else
    begin
      near_full_q  <= near_full;
      near_empty_q <= near_empty;
      err_q        <= hw_evt_i.error_flags;
    end
  end

  // ==========================================================================
  // Event status register; software write first, hardware set on top
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      events <= RFES_RST_EVENTS; // R10
    end
    else if (wr_any && hit_evt)
    begin
      if (acc_i.wdata[RFES_EVT_SET_BIT])
      begin
        events <= events | acc_i.wdata[6:0] | hw_set; // R11
      end
      else
      begin
        // Set wins so an event landing on its own clear is kept
        events <= (events & ~acc_i.wdata[6:0]) | hw_set; // R11 R22
      end
    end
    else
    begin
      events <= events | hw_set; // R12 R13
    end
  end

  // ==========================================================================
  // Control and threshold registers
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      depth_sel <= RFES_RST_DEPTH_SEL;
      threshold <= RFES_RST_THRESHOLD;
    end
    else if (wr_any && hit_ctl)
    begin
      // Not blocked when non-empty; software empties first by convention
      depth_sel    <= acc_i.wdata[RFES_CTL_DEPTH_SEL_BIT]; // R4
      threshold[8] <= acc_i.wdata[RFES_CTL_THR_MSB_BIT];   // R1
    end
    else if (wr_any && hit_thr)
    begin
      threshold[7:0] <= acc_i.wdata; // R1
    end
  end

  // ==========================================================================
  // Buffer pointers and byte count, moved by hardware only
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      count  <= RFES_RST_COUNT; // R7
    end
    else if (flush)
    begin
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      count  <= RFES_RST_COUNT; // R5
    end
    else if (push)
    begin
      wr_ptr <= wr_ptr + 9'h001;
      count  <= count + 10'h001; // R8
    end
    else if (pop)
    begin
      rd_ptr <= rd_ptr + 9'h001;
      count  <= count - 10'h001; // R8
    end
  end

  // Array write; no reset so it maps onto plain memory
  // Words beyond the count are stale; only the count says what is held
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= acc_i.wdata;
    end
  end

  // ==========================================================================
  // Address pointer: loaded by the host side, otherwise advanced after each access except at the data port
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      addr_ptr <= RFES_RST_ADDR_PTR;
    end
    else if (acc_i.load)
    begin
      addr_ptr <= acc_i.addr;
    end
    else if (acc_i.valid && !hit_port)
    begin
      addr_ptr <= addr_ptr + 7'h01; // R9
    end
  end

  // ==========================================================================
  // Read data, one cycle after the access
  // An empty data port still answers, so the host never waits on a refused read
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_o  <= RFES_RST_RDATA;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_any;
      if (rd_any)
      begin
        unique case (addr_ptr)
          RFES_OFS_BUFFER_CONTROL:
            // Clear bit and spare bit always read 0
            rdata_o <= {depth_sel, near_full, near_empty, 2'b00,
                        threshold[8], 1'b0, 1'b0} | {6'h00, count[9:8]}; // R5 R6
          RFES_OFS_FILL_THRESHOLD:
            rdata_o <= threshold[7:0];
          RFES_OFS_BYTE_COUNT:
            rdata_o <= count[7:0]; // R7
          RFES_OFS_ACCESS_PORT:
            // An empty buffer answers zero and keeps its count
            rdata_o <= pop ? mem[rd_ptr] : 8'h00;
          RFES_OFS_EVENT_STATUS:
            rdata_o <= {1'b0, events}; // R22
          default:
            rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // Registered status copies for the rest of the device
  // They trail the live state by one cycle, which status readers must allow for
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      addr_ptr_o   <= RFES_RST_ADDR_PTR;
      cmd_field_o  <= RFES_CMD_IDLE;
      events_o     <= RFES_RST_EVENTS;
      near_full_o  <= 1'b0;
      near_empty_o <= 1'b1;
      byte_count_o <= RFES_RST_COUNT;
    end
    else
    begin
      addr_ptr_o   <= addr_ptr;
      cmd_field_o  <= cmd_field;
      events_o     <= events;
      near_full_o  <= near_full;
      near_empty_o <= near_empty;
      byte_count_o <= count;
    end
  end

endmodule : rfes_top

// *** rtl/rfes_pkg.sv ***
// Package of constants and carrier types for the reader buffer and event status block
package rfes_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [6:0] RFES_OFS_BUFFER_CONTROL = 7'h02;
  localparam logic [6:0] RFES_OFS_FILL_THRESHOLD = 7'h03;
  localparam logic [6:0] RFES_OFS_BYTE_COUNT     = 7'h04;
  localparam logic [6:0] RFES_OFS_ACCESS_PORT    = 7'h05;
  localparam logic [6:0] RFES_OFS_EVENT_STATUS   = 7'h06;

  // ==========================================================================
  // Buffer control field positions
  localparam int RFES_CTL_DEPTH_SEL_BIT  = 7;
  localparam int RFES_CTL_NEAR_FULL_BIT  = 6;
  localparam int RFES_CTL_NEAR_EMPTY_BIT = 5;
  localparam int RFES_CTL_CLEAR_BIT      = 4;
  localparam int RFES_CTL_THR_MSB_BIT    = 2;

  // ==========================================================================
  // Event status field positions
  localparam int RFES_EVT_SET_BIT        = 7;
  localparam int RFES_EVT_NEAR_FULL      = 6;
  localparam int RFES_EVT_NEAR_EMPTY     = 5;
  localparam int RFES_EVT_CMD_DONE       = 4;
  localparam int RFES_EVT_TX_DONE        = 3;
  localparam int RFES_EVT_RX_END         = 2;
  localparam int RFES_EVT_ERROR          = 1;
  localparam int RFES_EVT_FRAME_START    = 0;

  // ==========================================================================
  // Depths, reset values and command codes
  localparam logic [9:0] RFES_DEPTH_SMALL      = 10'h0FF;
  localparam logic [9:0] RFES_DEPTH_LARGE      = 10'h200;
  localparam logic       RFES_RST_DEPTH_SEL    = 1'h0;
  localparam logic [8:0] RFES_RST_THRESHOLD    = 9'h000;
  localparam logic [9:0] RFES_RST_COUNT        = 10'h000;
  localparam logic [6:0] RFES_RST_EVENTS       = 7'h00;
  localparam logic [7:0] RFES_RST_RDATA        = 8'h00;
  localparam logic [6:0] RFES_RST_ADDR_PTR     = 7'h00;
  localparam logic [4:0] RFES_CMD_IDLE         = 5'h00;

  // ==========================================================================
  // Host register access, one per cycle at most
  typedef struct packed {
    logic       load;    // Load the address pointer from addr
    logic [6:0] addr;
    logic       valid;   // Access at the current pointer
    logic       write;
    logic [7:0] wdata;
  } rfes_acc_t;

  // Transceiver side event sources, one-cycle pulses except error levels
  typedef struct packed {
    logic       tx_done;
    logic       rx_end;
    logic       frame_start;
    logic [4:0] error_flags; // write, overflow, protocol, empty send, integrity
  } rfes_hw_evt_t;

endpackage : rfes_pkg

// *** tb/rfes_top_asserts.sv ***
// Port checker for the reader buffer and event status block
`timescale 1ns/1ps
// ==========
// Checker
module rfes_top_asserts
  import rfes_pkg::*;
#(
  parameter logic [31:0] CMD_DEFINED_MASK = 32'h0000_FFFF
)(
  input wire logic         clk_i,
  input wire logic         sys_rst_i,
  input wire rfes_acc_t    acc_i,
  input wire rfes_hw_evt_t hw_evt_i,
  input wire logic         cmd_start_i,
  input wire logic [4:0]   cmd_code_i,
  input wire logic         cmd_self_end_i,
  input wire logic [7:0]   rdata_o,
  input wire logic         rvalid_o,
  input wire logic [6:0]   addr_ptr_o,
  input wire logic [4:0]   cmd_field_o,
  input wire logic [6:0]   events_o,
  input wire logic         near_full_o,
  input wire logic         near_empty_o,
  input wire logic [9:0]   byte_count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Pointer output lags one cycle, so the pointer used shows the cycle after
  sequence s_port_acc; acc_i.valid && !acc_i.load ##1 addr_ptr_o == 7'h05; endsequence
  sequence s_reg_acc; acc_i.valid && !acc_i.load ##1 addr_ptr_o != 7'h05; endsequence
  property p_read_ans; acc_i.valid && !acc_i.write |=> rvalid_o; endproperty
  property p_port_hold; s_port_acc |=> addr_ptr_o == 7'h05; endproperty
  property p_reg_step; s_reg_acc |=> addr_ptr_o == $past(addr_ptr_o) + 7'h01; endproperty
  property p_tx; hw_evt_i.tx_done |-> ##2 events_o[RFES_EVT_TX_DONE]; endproperty
  property p_err;
    |(hw_evt_i.error_flags & ~$past(hw_evt_i.error_flags)) |-> ##[1:2] events_o[1];
  endproperty
  property p_nfull; $rose(near_full_o) |-> ##[0:2] events_o[6]; endproperty
  property p_nempty; $rose(near_empty_o) |-> ##[0:2] events_o[5]; endproperty
  property p_undef;
    cmd_start_i && !CMD_DEFINED_MASK[cmd_code_i] |-> ##2 cmd_field_o == 5'h00 && events_o[4];
  endproperty
  property p_empty; byte_count_o == 10'h000 |-> near_empty_o; endproperty
  a_read_ans: assert property (p_read_ans) else $error("no read answer");
  a_port_hold: assert property (p_port_hold) else $error("port moved pointer");
  a_reg_step: assert property (p_reg_step) else $error("pointer not advanced");
  a_tx: assert property (p_tx) else $error("transmit event missing");
  a_err: assert property (p_err) else $error("error event missing");
  a_nfull: assert property (p_nfull) else $error("near full event missing");
  a_nempty: assert property (p_nempty) else $error("near empty event missing");
  a_undef: assert property (p_undef) else $error("undefined command kept");
  a_empty: assert property (p_empty) else $error("near empty flag low");
endmodule : rfes_top_asserts

bind rfes_top rfes_top_asserts #(.CMD_DEFINED_MASK(CMD_DEFINED_MASK)) u_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .acc_i(acc_i), .hw_evt_i(hw_evt_i),
  .cmd_start_i(cmd_start_i), .cmd_code_i(cmd_code_i), .cmd_self_end_i(cmd_self_end_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .addr_ptr_o(addr_ptr_o), .cmd_field_o(cmd_field_o),
  .events_o(events_o), .near_full_o(near_full_o), .near_empty_o(near_empty_o),
  .byte_count_o(byte_count_o));

// *** tb/rfes_xcvr_model.sv ***
// Transceiver event source model driving the block's hardware event inputs
`timescale 1ns/1ps
// ==========
// Event source
module rfes_xcvr_model
  import rfes_pkg::*;
(
  input  wire logic   clk_i,
  output rfes_hw_evt_t evt_o
);
  initial evt_o = '0;
  // One-cycle pulses, sel is {frame start, receive end, transmit done}
  task automatic pulse(input logic [2:0] sel);
    @(posedge clk_i);
    evt_o.tx_done <= sel[0];
    evt_o.rx_end <= sel[1];
    evt_o.frame_start <= sel[2];
    @(posedge clk_i);
    evt_o.tx_done <= 1'b0;
    evt_o.rx_end <= 1'b0;
    evt_o.frame_start <= 1'b0;
  endtask : pulse
  // Error flags are levels; only a rising bit counts as a new error
  task automatic set_err(input logic [4:0] f);
    @(posedge clk_i);
    evt_o.error_flags <= f;
  endtask : set_err
endmodule : rfes_xcvr_model

// *** tb/reader_fifo_and_event_status_bench.sv ***
// Self-checking bench for the reader buffer and event status block
`timescale 1ns/1ps
// ==========
// Bench
module reader_fifo_and_event_status_bench;
  import rfes_pkg::*;
  logic clk_i = 1'b0;
  logic rst = 1'b1;
  rfes_acc_t acc = '0;
  rfes_hw_evt_t evt;
  logic cs = 1'b0;
  logic [4:0] code = 5'h00;
  logic ce = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic [6:0] ptr;
  logic [4:0] field;
  logic [6:0] events;
  logic [9:0] count;
  logic nf;
  logic ne;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 clk_i = ~clk_i;
  rfes_top i_dut (.clk_i(clk_i), .sys_rst_i(rst), .acc_i(acc), .hw_evt_i(evt),
    .cmd_start_i(cs), .cmd_code_i(code), .cmd_self_end_i(ce), .rdata_o(rdata),
    .rvalid_o(rvalid), .addr_ptr_o(ptr), .cmd_field_o(field), .events_o(events),
    .near_full_o(nf), .near_empty_o(ne), .byte_count_o(count));
  rfes_xcvr_model i_xcvr (.clk_i(clk_i), .evt_o(evt));
  // ==========
  // Access tasks; every request is launched on a rising edge
  task automatic put(input logic l, input logic [6:0] a, input logic v, input logic w,
                     input logic [7:0] d);
    @(posedge clk_i);
    acc <= '{load: l, addr: a, valid: v, write: w, wdata: d};
  endtask : put
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    put(1'b1, a, 1'b0, 1'b0, 8'h00);
    put(1'b0, a, 1'b1, 1'b1, d);
    put(1'b0, a, 1'b0, 1'b0, 8'h00);
  endtask : wr
  // Bounded wait for the answer pulse
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    int n;
    put(1'b1, a, 1'b0, 1'b0, 8'h00);
    put(1'b0, a, 1'b1, 1'b0, 8'h00);
    put(1'b0, a, 1'b0, 1'b0, 8'h00);
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({9'h000, rvalid}, 10'h001);
    chk({2'b00, rdata}, {2'b00, exp});
  endtask : rd
  // Back-to-back pushes at the data port
  task automatic fill(input int n, input logic [7:0] d);
    put(1'b1, 7'h05, 1'b0, 1'b0, 8'h00);
    repeat (n) put(1'b0, 7'h05, 1'b1, 1'b1, d);
    put(1'b0, 7'h05, 1'b0, 1'b0, 8'h00);
    repeat (3) @(posedge clk_i);
  endtask : fill
  task automatic cmd(input logic s, input logic [4:0] c, input logic e);
    @(posedge clk_i);
    cs <= s;
    code <= c;
    ce <= e;
    @(posedge clk_i);
    cs <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : cmd
  task automatic conclude();
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // Hang guard well above the expected run length
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errors++;
      conclude();
    end
  end
  // ==========
  // Scenarios
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst <= 1'b0;
    rd(7'h04, 8'h00);
    rd(7'h06, 8'h00);
    wr(7'h06, 8'hFF);
    rd(7'h06, 8'h7F);
    wr(7'h06, 8'h85);
    wr(7'h06, 8'h44);
    rd(7'h06, 8'h3B);
    wr(7'h06, 8'h7F);
    wr(7'h04, 8'h55);
    rd(7'h04, 8'h00);
    rd(7'h40, 8'h00);
    fill(3, 8'hA5);
    chk(count, 10'h003);
    chk({3'b000, ptr}, 10'h005);
    rd(7'h05, 8'hA5);
    rd(7'h04, 8'h02);
    rd(7'h05, 8'hA5);
    rd(7'h05, 8'hA5);
    rd(7'h06, 8'h20);
    wr(7'h06, 8'h7F);
    wr(7'h03, 8'h02);
    rd(7'h03, 8'h02);
    wr(7'h02, 8'h80);
    fill(256, 8'h5A);
    chk(count, 10'h0FF);
    chk({8'h00, nf, ne}, 10'h002);
    rd(7'h02, 8'hC0);
    wr(7'h02, 8'h90);
    repeat (2) @(posedge clk_i);
    chk(count, 10'h000);
    chk({8'h00, nf, ne}, 10'h001);
    rd(7'h02, 8'hA0);
    rd(7'h06, 8'h60);
    wr(7'h02, 8'h04);
    fill(300, 8'h3C);
    rd(7'h04, 8'h2C);
    rd(7'h02, 8'h45);
    wr(7'h02, 8'h10);
    wr(7'h06, 8'h7F);
    cmd(1'b1, 5'h1F, 1'b0);
    chk({5'h00, field}, 10'h000);
    rd(7'h06, 8'h10);
    wr(7'h06, 8'h7F);
    cmd(1'b1, 5'h00, 1'b0);
    rd(7'h06, 8'h00);
    cmd(1'b1, 5'h03, 1'b0);
    chk({5'h00, field}, 10'h003);
    cmd(1'b0, 5'h03, 1'b1);
    chk({5'h00, field}, 10'h000);
    rd(7'h06, 8'h10);
    wr(7'h06, 8'h7F);
    i_xcvr.pulse(3'b111);
    i_xcvr.set_err(5'h04);
    repeat (3) @(posedge clk_i);
    rd(7'h06, 8'h0F);
    chk({3'b000, events}, 10'h00F);
    i_xcvr.set_err(5'h00);
    wr(7'h06, 8'h7F);
    i_xcvr.pulse(3'b010);
    rd(7'h06, 8'h04);
    conclude();
  end
endmodule : reader_fifo_and_event_status_bench
